// file: slip_buf_model.sv
`timescale 1ns/1ps
`default_nettype none

module slip_buf_model (
  input  wire logic       mclk_i,
  input  wire logic       rst_n_i,
  input  wire logic [7:0] cmd_i,
  output var  logic [7:0] buf_o
);
  // ----------------------------------------------------------------
  // Buffer levels and access attempts, one cycle behind the command
  // ----------------------------------------------------------------
  // Order: tx empty, tx full, tx rd, tx wr, rx empty, rx full, rx rd, rx wr
  always @(posedge mclk_i) begin
    buf_o <= rst_n_i ? cmd_i : 8'h00;
  end
endmodule

`default_nettype wire

// file: slip_buffer_irq_enable.sv
// Our own choices: strobed register access and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module slip_buffer_irq_enable #(
  parameter int unsigned ADDR_W = slip_irq_pkg::ADDR_W
) (
  input  wire logic                           mclk_i,
  input  wire logic                           rst_n_i,
  input  wire logic [ADDR_W-1:0]              addr_i,
  input  wire logic [slip_irq_pkg::DATA_W-1:0] wr_data_i,
  input  wire logic                           wr_i,
  input  wire logic                           rd_i,
  output var  logic [slip_irq_pkg::DATA_W-1:0] rd_data_o,
  input  wire logic                           tx_empty_i,
  input  wire logic                           tx_full_i,
  input  wire logic                           tx_rd_i,
  input  wire logic                           tx_wr_i,
  input  wire logic                           rx_empty_i,
  input  wire logic                           rx_full_i,
  input  wire logic                           rx_rd_i,
  input  wire logic                           rx_wr_i,
  output var  logic                           tx_repeat_o,
  output var  logic                           tx_delete_o,
  output var  logic                           rx_repeat_o,
  output var  logic                           rx_delete_o,
  output var  logic                           irq_o
);

  import slip_irq_pkg::*;

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  // Register offsets are eight-bit constants; the address must hold all eight bits
  if (ADDR_W < 8) begin : g_bad_addr
    $error("ADDR_W must be at least 8");
  end

  // ----------------------------------------------------------------
  // Types and state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [DATA_W-1:0] enable;
    logic [DATA_W-1:0] status;
    logic [DATA_W-1:0] rd_data;
    logic              irq;
  } ctrl_state_t;

  ctrl_state_t       state_ff;
  ctrl_state_t       nxt_state;
  logic [DATA_W-1:0] set_vec;
  logic [DATA_W-1:0] clr_vec;
  logic [DATA_W-1:0] gate_vec;
  logic              tx_rep;
  logic              tx_del;
  logic              rx_rep;
  logic              rx_del;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Upper address bits must be zero so aliases do not hit registers
  function automatic logic addr_hit(input logic [ADDR_W-1:0] a,
                                    input logic [7:0]        reg_addr);
    addr_hit = (a == ADDR_W'(reg_addr));
  endfunction

  // ----------------------------------------------------------------
  // Frame slip detection per buffer
  // ----------------------------------------------------------------
  slip_event_gen u_tx_gen (
    .mclk_i   (mclk_i),
    .rst_n_i  (rst_n_i),
    .empty_i  (tx_empty_i),
    .full_i   (tx_full_i),
    .rd_i     (tx_rd_i),
    .wr_i     (tx_wr_i),
    .repeat_o (tx_rep),
    .delete_o (tx_del)
  );

  slip_event_gen u_rx_gen (
    .mclk_i   (mclk_i),
    .rst_n_i  (rst_n_i),
    .empty_i  (rx_empty_i),
    .full_i   (rx_full_i),
    .rd_i     (rx_rd_i),
    .wr_i     (rx_wr_i),
    .repeat_o (rx_rep),
    .delete_o (rx_del)
  );

  // ----------------------------------------------------------------
  // Event vector
  // ----------------------------------------------------------------
  always_comb begin
    set_vec               = '0;
    set_vec[TX_EMPTY_BIT] = tx_rep;
    set_vec[TX_SLIP_BIT]  = tx_rep | tx_del;
    set_vec[RX_FULL_BIT]  = rx_del;
    set_vec[RX_EMPTY_BIT] = rx_rep;
    set_vec[RX_SLIP_BIT]  = rx_rep | rx_del;
  end

  // ----------------------------------------------------------------
  // Register port and interrupt
  // ----------------------------------------------------------------
  always_comb begin
    nxt_state         = state_ff;
    nxt_state.rd_data = '0;
    clr_vec           = '0;
    if (wr_i && addr_hit(addr_i, ENABLE_ADDR)) begin
      nxt_state.enable = wr_data_i & IRQ_MASK;
    end
    if (wr_i && addr_hit(addr_i, CLEAR_ADDR)) begin
      clr_vec = wr_data_i;
    end
    if (rd_i) begin
      if (addr_hit(addr_i, STATUS_ADDR)) begin
        // Read returns the flags before the clear takes effect
        nxt_state.rd_data = state_ff.status;
        clr_vec           = ALL_ONES;
      end else if (addr_hit(addr_i, ENABLE_ADDR)) begin
        nxt_state.rd_data = state_ff.enable;
      end else begin
        nxt_state.rd_data = '0;
      end
    end
    // Set beats clear so a slip in the read cycle is kept
    nxt_state.status = ((state_ff.status & ~clr_vec) | set_vec)
                       & IRQ_MASK;
    // Uses the next values so irq_o and status move together
    gate_vec               = '0;
    gate_vec[TX_EMPTY_BIT] = nxt_state.status[TX_EMPTY_BIT]
                             & nxt_state.enable[TX_EMPTY_BIT];
    gate_vec[TX_SLIP_BIT]  = nxt_state.status[TX_SLIP_BIT]
                             & nxt_state.enable[TX_SLIP_BIT];
    gate_vec[RX_FULL_BIT]  = nxt_state.status[RX_FULL_BIT]
                             & nxt_state.enable[RX_FULL_BIT];
    gate_vec[RX_EMPTY_BIT] = nxt_state.status[RX_EMPTY_BIT]
                             & nxt_state.enable[RX_EMPTY_BIT];
    gate_vec[RX_SLIP_BIT]  = nxt_state.status[RX_SLIP_BIT]
                             & nxt_state.enable[RX_SLIP_BIT];
    nxt_state.irq          = |gate_vec;
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      state_ff.enable  <= ENABLE_RESET;
      state_ff.status  <= STATUS_RESET;
      state_ff.rd_data <= '0;
      state_ff.irq     <= 1'b0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign rd_data_o   = state_ff.rd_data;
  assign irq_o       = state_ff.irq;
  assign tx_repeat_o = tx_rep;
  assign tx_delete_o = tx_del;
  assign rx_repeat_o = rx_rep;
  assign rx_delete_o = rx_del;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  AST_TX_EMPTY_GATE: assert property (@(posedge mclk_i)
    disable iff (!rst_n_i)
    (state_ff.status[TX_EMPTY_BIT] && state_ff.enable[TX_EMPTY_BIT])
    |-> irq_o)
    else $error("enabled tx empty flag did not raise irq");

  AST_TX_REPLAY: assert property (@(posedge mclk_i)
    disable iff (!rst_n_i)
    (tx_empty_i && tx_rd_i) |=> tx_repeat_o ##1
    state_ff.status[TX_EMPTY_BIT])
    else $error("tx underflow did not replay and flag");

  AST_TX_SLIP: assert property (@(posedge mclk_i)
    disable iff (!rst_n_i)
    (tx_repeat_o || tx_delete_o) |=> state_ff.status[TX_SLIP_BIT])
    else $error("tx slip flag missed");

  AST_TX_DISCARD: assert property (@(posedge mclk_i)
    disable iff (!rst_n_i)
    (tx_full_i && tx_wr_i) |-> ##2 state_ff.status[TX_SLIP_BIT])
    else $error("tx overflow did not set slip flag");

  AST_RX_FULL: assert property (@(posedge mclk_i)
    disable iff (!rst_n_i)
    (rx_full_i && rx_wr_i) |=> rx_delete_o ##1
    (state_ff.status[RX_FULL_BIT] && state_ff.status[RX_SLIP_BIT]))
    else $error("rx overflow did not delete and flag");

  AST_RX_EMPTY: assert property (@(posedge mclk_i)
    disable iff (!rst_n_i)
    (rx_empty_i && rx_rd_i) |-> ##2
    (state_ff.status[RX_EMPTY_BIT] && state_ff.status[RX_SLIP_BIT]))
    else $error("rx underflow did not set flags");

  AST_RX_SLIP_ONLY: assert property (@(posedge mclk_i)
    disable iff (!rst_n_i)
    $rose(state_ff.status[RX_SLIP_BIT]) |-> $past(rx_rep || rx_del))
    else $error("rx slip flag set without an rx slip");

  AST_RD_CLEAR: assert property (@(posedge mclk_i)
    disable iff (!rst_n_i)
    (rd_i && addr_i == ADDR_W'(STATUS_ADDR)) |=>
    (rd_data_o == $past(state_ff.status)) &&
    (state_ff.status == $past(set_vec & IRQ_MASK)))
    else $error("status read did not return and clear flags");

  AST_IRQ_NONE: assert property (@(posedge mclk_i)
    disable iff (!rst_n_i)
    (state_ff.enable == '0) |-> !irq_o)
    else $error("irq raised with all enables clear");

  AST_RX_GATE: assert property (@(posedge mclk_i)
    disable iff (!rst_n_i)
    (state_ff.status == 8'h01 && !state_ff.enable[RX_SLIP_BIT])
    |-> !irq_o)
    else $error("disabled rx slip raised irq");

  AST_RD_PULSE: assert property (@(posedge mclk_i)
    disable iff (!rst_n_i)
    !$past(rd_i) |-> (rd_data_o == '0))
    else $error("read data outside read answer cycle");

  AST_TX_SLIP_GATE: assert property (@(posedge mclk_i)
    disable iff (!rst_n_i)
    (state_ff.status[TX_SLIP_BIT] && state_ff.enable[TX_SLIP_BIT])
    |-> irq_o)
    else $error("enabled tx slip flag did not raise irq");

  AST_RX_FULL_GATE: assert property (@(posedge mclk_i)
    disable iff (!rst_n_i)
    (state_ff.status[RX_FULL_BIT] && state_ff.enable[RX_FULL_BIT])
    |-> irq_o)
    else $error("enabled rx full flag did not raise irq");

  AST_RX_EMPTY_GATE: assert property (@(posedge mclk_i)
    disable iff (!rst_n_i)
    (state_ff.status[RX_EMPTY_BIT] && state_ff.enable[RX_EMPTY_BIT])
    |-> irq_o)
    else $error("enabled rx empty flag did not raise irq");

  AST_RX_SLIP_GATE: assert property (@(posedge mclk_i)
    disable iff (!rst_n_i)
    (state_ff.status[RX_SLIP_BIT] && state_ff.enable[RX_SLIP_BIT])
    |-> irq_o)
    else $error("enabled rx slip flag did not raise irq");

  AST_IRQ_ONLY: assert property (@(posedge mclk_i)
    disable iff (!rst_n_i)
    irq_o |-> ((state_ff.status & state_ff.enable) != '0))
    else $error("irq raised without an enabled flag");

  AST_RESET_VALUES: assert property (@(posedge mclk_i)
    !rst_n_i |=> (state_ff.enable == ENABLE_RESET &&
    state_ff.status == STATUS_RESET && !irq_o && rd_data_o == '0))
    else $error("reset did not clear enables, flags and outputs");

  // Only a status read or a clear write may drop a flag
  AST_STICKY: assert property (@(posedge mclk_i)
    disable iff (!rst_n_i)
    (!(rd_i && addr_hit(addr_i, STATUS_ADDR)) &&
     !(wr_i && addr_hit(addr_i, CLEAR_ADDR))) |=>
    ((state_ff.status & $past(state_ff.status)) == $past(state_ff.status)))
    else $error("status flag dropped without a read or clear");

  AST_TX_EMPTY_SRC: assert property (@(posedge mclk_i)
    disable iff (!rst_n_i)
    $rose(state_ff.status[TX_EMPTY_BIT]) |-> $past(tx_rep))
    else $error("tx empty flag set without a replay");

  AST_TX_SLIP_SRC: assert property (@(posedge mclk_i)
    disable iff (!rst_n_i)
    $rose(state_ff.status[TX_SLIP_BIT]) |-> $past(tx_rep || tx_del))
    else $error("tx slip flag set without a tx slip");

  AST_RX_FULL_SRC: assert property (@(posedge mclk_i)
    disable iff (!rst_n_i)
    $rose(state_ff.status[RX_FULL_BIT]) |-> $past(rx_del))
    else $error("rx full flag set without a delete");

  AST_RX_EMPTY_SRC: assert property (@(posedge mclk_i)
    disable iff (!rst_n_i)
    $rose(state_ff.status[RX_EMPTY_BIT]) |-> $past(rx_rep))
    else $error("rx empty flag set without a repeat");

  AST_UNMAPPED_READ: assert property (@(posedge mclk_i)
    disable iff (!rst_n_i)
    (rd_i && !addr_hit(addr_i, STATUS_ADDR) &&
     !addr_hit(addr_i, ENABLE_ADDR)) |=> (rd_data_o == '0))
    else $error("unmapped read returned data");

  AST_ENABLE_WRITE: assert property (@(posedge mclk_i)
    disable iff (!rst_n_i)
    (wr_i && addr_hit(addr_i, ENABLE_ADDR)) |=>
    (state_ff.enable == $past(wr_data_i & IRQ_MASK)))
    else $error("enable write not stored");

  AST_RSVD_ZERO: assert property (@(posedge mclk_i)
    disable iff (!rst_n_i)
    ((state_ff.status | state_ff.enable) & ~IRQ_MASK) == '0)
    else $error("reserved flag or enable bit set");

  // ----------------------------------------------------------------
  // Cover points
  // ----------------------------------------------------------------
  COV_TX_REPLAY: cover property (@(posedge mclk_i)
    disable iff (!rst_n_i)
    tx_repeat_o ##1 irq_o);

  COV_RX_DELETE: cover property (@(posedge mclk_i)
    disable iff (!rst_n_i)
    rx_delete_o ##1 state_ff.status[RX_FULL_BIT]);

  COV_SET_AND_CLEAR: cover property (@(posedge mclk_i)
    disable iff (!rst_n_i)
    (rd_i && addr_i == ADDR_W'(STATUS_ADDR) && set_vec != '0));

  COV_RX_SLIP_MASKED: cover property (@(posedge mclk_i)
    disable iff (!rst_n_i)
    state_ff.status == 8'h01 && !state_ff.enable[RX_SLIP_BIT]);

  COV_READ_DROPS_IRQ: cover property (@(posedge mclk_i)
    disable iff (!rst_n_i)
    (irq_o && rd_i && addr_i == ADDR_W'(STATUS_ADDR)) ##1 !irq_o);

endmodule

`default_nettype wire

// file: slip_event_gen.sv
`timescale 1ns/1ps
`default_nettype none

module slip_event_gen (
  input  wire logic mclk_i,
  input  wire logic rst_n_i,
  input  wire logic empty_i,
  input  wire logic full_i,
  input  wire logic rd_i,
  input  wire logic wr_i,
  output var  logic repeat_o,
  output var  logic delete_o
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic repeat_ev;
    logic delete_ev;
  } gen_state_t;

  gen_state_t state_ff;
  gen_state_t nxt_state;

  // ----------------------------------------------------------------
  // Underflow repeats a frame, overflow drops one
  // ----------------------------------------------------------------
  always_comb begin
    nxt_state           = state_ff;
    nxt_state.repeat_ev = empty_i & rd_i;
    nxt_state.delete_ev = full_i & wr_i;
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign repeat_o = state_ff.repeat_ev;
  assign delete_o = state_ff.delete_ev;

  AST_GEN_REPEAT: assert property (@(posedge mclk_i)
    disable iff (!rst_n_i)
    (empty_i && rd_i) |=> repeat_o)
    else $error("underflow did not raise a repeat");

  AST_GEN_DELETE: assert property (@(posedge mclk_i)
    disable iff (!rst_n_i)
    (full_i && wr_i) |=> delete_o)
    else $error("overflow did not raise a delete");

endmodule

`default_nettype wire

// file: slip_irq_pkg.sv
package slip_irq_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W       = 8;
  localparam int unsigned DATA_W       = 8;
  localparam logic [7:0]  STATUS_ADDR  = 8'h08;
  localparam logic [7:0]  ENABLE_ADDR  = 8'h09;
  localparam logic [7:0]  CLEAR_ADDR   = 8'h0C;

  // ----------------------------------------------------------------
  // Field positions, shared by status, enable and clear
  // ----------------------------------------------------------------
  localparam int unsigned RX_SLIP_BIT  = 0;
  localparam int unsigned RX_EMPTY_BIT = 1;
  localparam int unsigned RX_FULL_BIT  = 2;
  localparam int unsigned TX_SLIP_BIT  = 5;
  localparam int unsigned TX_EMPTY_BIT = 6;

  // ----------------------------------------------------------------
  // Reset values and masks
  // ----------------------------------------------------------------
  localparam logic [7:0]  IRQ_MASK     = 8'h67;
  localparam logic [7:0]  ENABLE_RESET = 8'h00;
  localparam logic [7:0]  STATUS_RESET = 8'h00;
  localparam logic [7:0]  ALL_ONES     = 8'hFF;

endpackage

// file: tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb;
  import slip_irq_pkg::*;
  logic       mclk_i    = 1'b0;
  logic       rst_n_i   = 1'b0;
  logic [7:0] addr_i    = 8'h00;
  logic [7:0] wr_data_i = 8'h00;
  logic       wr_i      = 1'b0;
  logic       rd_i      = 1'b0;
  logic [7:0] cmd       = 8'h00;
  wire  [7:0] bi;
  wire  [7:0] rd_data_o;
  wire  [3:0] pl_o;
  wire        irq_o;
  int         failures  = 0;
  int         samples_checked = 0;
  logic [7:0] m_st, m_en, m_rd, n_st, n_en, clr, set;
  logic [3:0] m_pl;
  logic       m_irq;
  logic [7:0] en_tab [5] = '{8'h01, 8'h02, 8'h04, 8'h20, 8'h40};
  logic [7:0] ev_tab [4] = '{8'hA0, 8'h50, 8'h0A, 8'h05};
  logic [7:0] ad_tab [3] = '{STATUS_ADDR, ENABLE_ADDR, CLEAR_ADDR};
  int         r;

  slip_buf_model slip_buf_model_i (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n_i),
    .cmd_i   (cmd),
    .buf_o   (bi)
  );

  slip_buffer_irq_enable slip_buffer_irq_enable_i (
    .mclk_i      (mclk_i),
    .rst_n_i     (rst_n_i),
    .addr_i      (addr_i),
    .wr_data_i   (wr_data_i),
    .wr_i        (wr_i),
    .rd_i        (rd_i),
    .rd_data_o   (rd_data_o),
    .tx_empty_i  (bi[7]),
    .tx_full_i   (bi[6]),
    .tx_rd_i     (bi[5]),
    .tx_wr_i     (bi[4]),
    .rx_empty_i  (bi[3]),
    .rx_full_i   (bi[2]),
    .rx_rd_i     (bi[1]),
    .rx_wr_i     (bi[0]),
    .tx_repeat_o (pl_o[3]),
    .tx_delete_o (pl_o[2]),
    .rx_repeat_o (pl_o[1]),
    .rx_delete_o (pl_o[0]),
    .irq_o       (irq_o)
  );

  // ----------------------------------------------------------------
  // Reference model; set wins over any clear in the same cycle
  // ----------------------------------------------------------------
  always @(posedge mclk_i) begin
    clr = 8'h00;
    if (rd_i && addr_i == STATUS_ADDR) clr = ALL_ONES;
    if (wr_i && addr_i == CLEAR_ADDR) clr = wr_data_i;
    set = {1'b0, m_pl[3], m_pl[3] | m_pl[2], 2'b00, m_pl[0], m_pl[1],
           m_pl[1] | m_pl[0]};
    n_st = (m_st & ~clr) | set;
    n_en = (wr_i && addr_i == ENABLE_ADDR) ? (wr_data_i & IRQ_MASK) : m_en;
    m_rd <= !rd_i ? 8'h00 : addr_i == STATUS_ADDR ? m_st :
            addr_i == ENABLE_ADDR ? m_en : 8'h00;
    m_pl <= {bi[7] & bi[5], bi[6] & bi[4], bi[3] & bi[1], bi[2] & bi[0]};
    m_irq <= |(n_st & n_en);
    m_st <= rst_n_i ? n_st : STATUS_RESET;
    m_en <= rst_n_i ? n_en : ENABLE_RESET;
    if (!rst_n_i) begin
      m_rd <= 8'h00;
      m_pl <= 4'h0;
      m_irq <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  task automatic note(input logic ok, input string what);
    samples_checked++;
    if (!ok) begin
      failures++;
      $display("[FAIL] %0t %s", $time, what);
    end
  endtask
  task automatic chk_pulse(input logic [3:0] got, input logic [3:0] exp);
    note(got === exp, "frame repeat or delete pulse wrong");
  endtask
  task automatic chk_data(input logic [7:0] got, input logic [7:0] exp);
    note(got === exp, "read data wrong");
  endtask
  task automatic chk_irq(input logic got, input logic exp);
    note(got === exp, "interrupt level wrong");
  endtask

  always @(negedge mclk_i) begin
    chk_pulse(pl_o, m_pl);
    chk_data(rd_data_o, m_rd);
    chk_irq(irq_o, m_irq);
  end

  // ----------------------------------------------------------------
  // Stimulus
  // ----------------------------------------------------------------
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    wr_i <= w;
    rd_i <= !w;
    addr_i <= a;
    wr_data_i <= d;
    @(posedge mclk_i);
    wr_i <= 1'b0;
    rd_i <= 1'b0;
  endtask
  task automatic fire(input logic [7:0] c);
    @(posedge mclk_i);
    cmd <= c;
    @(posedge mclk_i);
    cmd <= 8'h00;
    repeat (4) @(posedge mclk_i);
  endtask
  task automatic close_out();
    $display("checked %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial forever #2.5 mclk_i = ~mclk_i;
  initial begin
    #100000;
    failures++;
    close_out();
  end

  initial begin
    void'($urandom(47));
    repeat (2) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    // Reset values, reserved bits, write-only and unmapped places
    for (int i = 0; i < 3; i++) bus(1'b0, ad_tab[i], 8'h00);
    bus(1'b1, ENABLE_ADDR, ALL_ONES);
    bus(1'b0, ENABLE_ADDR, 8'h00);
    bus(1'b1, 8'h33, ALL_ONES);
    bus(1'b0, 8'h33, 8'h00);
    $display("test reset and map done");
    // Each enable bit against each event: only matching pairs interrupt
    for (int i = 0; i < 5; i++) begin
      for (int k = 0; k < 4; k++) begin
        bus(1'b1, ENABLE_ADDR, en_tab[i]);
        fire(ev_tab[k]);
        bus(1'b0, STATUS_ADDR, 8'h00);
      end
    end
    $display("test gating done");
    // Partial clear through the write-one-to-clear register
    bus(1'b1, ENABLE_ADDR, IRQ_MASK);
    fire(8'hFF);
    bus(1'b1, CLEAR_ADDR, 8'h05);
    bus(1'b0, STATUS_ADDR, 8'h00);
    // Receive slip left alone with its enable off must stay quiet
    bus(1'b1, ENABLE_ADDR, 8'h66);
    fire(8'h0A);
    bus(1'b1, CLEAR_ADDR, 8'h02);
    bus(1'b0, STATUS_ADDR, 8'h00);
    $display("test clear done");
    // Random traffic, strobes back to back, events colliding with clears
    repeat (3000) begin
      @(posedge mclk_i);
      cmd <= 8'($urandom & $urandom);
      r = $urandom % 4;
      wr_i <= (r == 1);
      rd_i <= (r == 2);
      addr_i <= ($urandom % 4 == 3) ? 8'($urandom) : ad_tab[$urandom % 3];
      wr_data_i <= 8'($urandom);
    end
    @(posedge mclk_i);
    wr_i <= 1'b0;
    rd_i <= 1'b0;
    $display("test random done");
    // Second reset in mid-run returns everything to zero
    rst_n_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    cmd <= 8'h00;
    bus(1'b0, ENABLE_ADDR, 8'h00);
    bus(1'b0, STATUS_ADDR, 8'h00);
    $display("test second reset done");
    close_out();
  end
endmodule

`default_nettype wire
